// ---- rtl/fsp_guard.sv ----
// Range check of one program or erase target against all protection.
`timescale 1ns/1ps
module fsp_guard import fsp_pkg::*; (
  // Protection state.
  input  wire logic [1:0]  level_i,
  input  wire logic        top_lock_i,
  input  wire logic        bottom_lock_i,
  // Target of the command.
  input  wire fsp_kind_t   kind_i,
  input  wire logic [23:0] addr_i,
  // Verdict.
  output logic             allow_o
);

  logic [23:0] lo;
  logic [23:0] hi;
  logic [23:0] plo;

  // Target span from the command kind, then test it against every lock.
  always_comb begin
    lo = addr_i;
    hi = addr_i;
    case (kind_i)
      KIND_AAI: hi = addr_i | 24'h000001;
      KIND_SECTOR: begin
        lo = addr_i & ~SECTOR_MASK;
        hi = addr_i | SECTOR_MASK;
      end
      KIND_BLOCK32: begin
        lo = addr_i & ~BLOCK32_MASK;
        hi = addr_i | BLOCK32_MASK;
      end
      KIND_BLOCK64: begin
        lo = addr_i & ~BLOCK64_MASK;
        hi = addr_i | BLOCK64_MASK;
      end
      KIND_CHIP: begin
        lo = 24'h000000;
        hi = ADDR_MAX;
      end
      default: ;
    endcase
    case (level_i)
      2'b01:   plo = LVL1_LO;
      2'b10:   plo = LVL2_LO;
      default: plo = LVL3_LO;
    endcase
    allow_o = (hi <= ADDR_MAX)
            && !((level_i != 2'b00) && (hi >= plo))
            && !(top_lock_i && (hi >= TOP_SECTOR_LO))
            && !(bottom_lock_i && (lo <= BOTTOM_SECTOR_HI));
    if (kind_i == KIND_CHIP && level_i != 2'b00) begin
      allow_o = 1'b0;
    end
  end

endmodule // fsp_guard

// ---- rtl/fsp_pkg.sv ----
// Constants and types of the flash status and write-protection block.
// =====================================================================
package fsp_pkg;

  // =====================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS      = 20;
  localparam int unsigned PROG_TIME_NS       = 10000;
  localparam int unsigned ERASE_TIME_NS      = 20000000;
  localparam int unsigned CHIP_ERASE_TIME_NS = 40000000;
  localparam int unsigned PROG_CYC       = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC      = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CHIP_ERASE_CYC = CHIP_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int          BUSY_CNT_W     = 22;

  // =====================================================================
  // Command codes.
  localparam logic [7:0] CMD_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE   = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE    = 8'h01;
  localparam logic [7:0] CMD_STATUS_WRITE_EN = 8'h50;
  localparam logic [7:0] CMD_STATUS_READ     = 8'h05;
  localparam logic [7:0] CMD_LOCK_READ       = 8'h35;
  localparam logic [7:0] CMD_BYTE_PROG       = 8'h02;
  localparam logic [7:0] CMD_AUTO_INC_PROG   = 8'had;
  localparam logic [7:0] CMD_SECTOR_ERASE    = 8'h20;
  localparam logic [7:0] CMD_BLOCK32_ERASE   = 8'h52;
  localparam logic [7:0] CMD_BLOCK64_ERASE   = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A    = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B    = 8'hc7;

  // =====================================================================
  // Frame lengths in bytes, opcode included.
  localparam logic [2:0] LEN_SHORT     = 3'd1;
  localparam logic [2:0] LEN_ERASE     = 3'd4;
  localparam logic [2:0] LEN_BYTE      = 3'd5;
  localparam logic [2:0] LEN_AAI_FIRST = 3'd6;
  localparam logic [2:0] LEN_AAI_NEXT  = 3'd3;
  localparam logic [2:0] LEN_SR_ONE    = 3'd2;
  localparam logic [2:0] LEN_SR_TWO    = 3'd3;

  // =====================================================================
  // Status field positions and reset values.
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_WEL_BIT      = 1;
  localparam int ST_LVL_LO_BIT   = 2;
  localparam int ST_LVL_HI_BIT   = 3;
  localparam int ST_AUTO_INC_BIT = 6;
  localparam int ST_LOCK_BIT     = 7;
  localparam int ST1_TOP_BIT     = 2;
  localparam int ST1_BOTTOM_BIT  = 3;
  localparam logic [1:0] RST_LEVEL   = 2'b11;
  localparam logic       RST_LOCK    = 1'b0;
  localparam logic       RST_SECTOR  = 1'b0;
  localparam logic [3:0] PIN_RST     = 4'h9;

  // =====================================================================
  // Address map.
  localparam logic [23:0] ADDR_MAX         = 24'h03ffff;
  localparam logic [23:0] LVL1_LO          = 24'h030000;
  localparam logic [23:0] LVL2_LO          = 24'h020000;
  localparam logic [23:0] LVL3_LO          = 24'h000000;
  localparam logic [23:0] TOP_SECTOR_LO    = 24'h03f000;
  localparam logic [23:0] BOTTOM_SECTOR_HI = 24'h000fff;
  localparam logic [23:0] SECTOR_MASK      = 24'h000fff;
  localparam logic [23:0] BLOCK32_MASK     = 24'h007fff;
  localparam logic [23:0] BLOCK64_MASK     = 24'h00ffff;
  localparam logic [23:0] AAI_STEP         = 24'h000002;

  // =====================================================================
  // Types.
  typedef enum logic [2:0] {
    KIND_NONE    = 3'b000,
    KIND_BYTE    = 3'b001,
    KIND_AAI     = 3'b010,
    KIND_SECTOR  = 3'b011,
    KIND_BLOCK32 = 3'b100,
    KIND_BLOCK64 = 3'b101,
    KIND_CHIP    = 3'b110
  } fsp_kind_t;

  typedef enum logic [1:0] {
    PH_RX   = 2'b00,
    PH_READ = 2'b01,
    PH_SKIP = 2'b10
  } fsp_phase_t;

  typedef struct packed {
    fsp_kind_t   kind;
    logic [23:0] addr;
    logic [15:0] data;
  } fsp_op_t;

  typedef struct packed {
    fsp_phase_t            phase;
    logic [2:0]            bit_cnt;
    logic [2:0]            byte_cnt;
    logic [7:0]            rx;
    logic [7:0]            opc;
    logic [39:0]           sh;
    logic [7:0]            tx;
    logic [2:0]            tx_cnt;
    logic                  sck_prev;
    logic                  cs_n_prev;
    logic                  busy;
    logic [BUSY_CNT_W-1:0] busy_cnt;
    logic                  write_enable_latch;
    logic                  ewsr;
    logic                  auto_increment_mode;
    logic [23:0]           aai_addr;
    logic [1:0]            level;
    logic                  lock;
    logic                  top_sector_lock;
    logic                  bottom_sector_lock;
    logic [7:0]            st0;
    logic [7:0]            st1;
    fsp_op_t               op;
    logic                  op_start;
    logic                  so;
    logic                  so_oe;
  } fsp_state_t;

endpackage

// ---- rtl/fsp_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps
module fsp_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Raw pins and filtered levels.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } fsp_sync_state_t;

  fsp_sync_state_t s_q;
  fsp_sync_state_t s_d;

  if (W < 1) begin : g_bad_width
    $error("fsp_sync needs at least one bit.");
  end

  // The first stage feeds only the second; the level moves when two and three agree.
  always_comb begin
    s_d     = s_q;
    s_d.s1  = d_i;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    s_d.lvl = (~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.lvl);
    if (rst_i) begin
      s_d.s1  = RST_VAL;
      s_d.s2  = RST_VAL;
      s_d.s3  = RST_VAL;
      s_d.lvl = RST_VAL;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign q_o = s_q.lvl;

endmodule // fsp_sync

// ---- rtl/fsp_top.sv ----
// Status registers, write-enable latch and write protection of the serial flash.
`timescale 1ns/1ps
module fsp_top import fsp_pkg::*; #(
  parameter int unsigned PROG_CYCLES  = PROG_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned CHIP_CYCLES  = CHIP_ERASE_CYC
) (
  // Clock and reset.
  input  wire logic  CLOCK_I,
  input  wire logic  RST_I,
  // Serial link pins.
  input  wire logic  CE_N_I,
  input  wire logic  SCK_I,
  input  wire logic  SI_I,
  output logic       SO_O,
  output logic       SO_OE_O,
  // Write-guard pin.
  input  wire logic  WP_N_I,
  // Register views.
  output logic [7:0] STATUS_O,
  output logic [7:0] LOCK_STATUS_O,
  // Request to the array engine.
  output logic       OP_START_O,
  output fsp_op_t    OP_O
);

  // =====================================================================
  // Parameter checks.
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << BUSY_CNT_W)) begin : g_bad_prog
    $error("PROG_CYCLES out of range.");
  end
  if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << BUSY_CNT_W)) begin : g_bad_erase
    $error("ERASE_CYCLES out of range.");
  end
  if (CHIP_CYCLES < 1 || CHIP_CYCLES >= (1 << BUSY_CNT_W)) begin : g_bad_chip
    $error("CHIP_CYCLES out of range.");
  end

  // =====================================================================
  // Declarations.
  fsp_state_t  s_q;
  fsp_state_t  s_d;
  logic [3:0]  pins;
  logic        cs_n_s;
  logic        sck_s;
  logic        si_s;
  logic        wp_n_s;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic [7:0]  rx_byte;
  fsp_kind_t   g_kind;
  logic [23:0] g_addr;
  logic [15:0] g_data;
  logic [2:0]  g_len;
  logic        g_ok;
  logic        wr_ok;
  logic [7:0]  sr0;
  logic [7:0]  sr1;

  // =====================================================================
  // Pin synchronisation and edge detection.
  fsp_sync #(
    .W       (4),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .d_i   ({WP_N_I, SI_I, SCK_I, CE_N_I}),
    .q_o   (pins)
  );

  // Filtered pin levels and their edges.
  assign cs_n_s   = pins[0];
  assign sck_s    = pins[1];
  assign si_s     = pins[2];
  assign wp_n_s   = pins[3];
  assign sck_rise = sck_s & ~s_q.sck_prev;
  assign sck_fall = ~sck_s & s_q.sck_prev;
  assign cs_rise  = cs_n_s & ~s_q.cs_n_prev;
  assign rx_byte  = {s_q.rx[6:0], si_s};

  // Protection fields may change when the guard is high or the lock is clear.
  assign wr_ok = wp_n_s | ~s_q.lock;

  // The first status byte sent with a write request.
  assign sr0 = (s_q.byte_cnt == LEN_SR_TWO) ? s_q.sh[15:8] : s_q.sh[7:0];
  assign sr1 = s_q.sh[7:0];

  // =====================================================================
  // Decode of the latched frame into an array target.
  always_comb begin
    g_kind = KIND_NONE;
    g_addr = s_q.sh[23:0] & ADDR_MAX;
    g_data = 16'h0000;
    g_len  = LEN_ERASE;
    case (s_q.opc)
      CMD_BYTE_PROG: begin
        g_kind = KIND_BYTE;
        g_addr = s_q.sh[31:8] & ADDR_MAX;
        g_data = {8'h00, s_q.sh[7:0]};
        g_len  = LEN_BYTE;
      end
      CMD_AUTO_INC_PROG: begin
        g_kind = KIND_AAI;
        g_data = s_q.sh[15:0];
        if (s_q.auto_increment_mode) begin
          g_addr = s_q.aai_addr;
          g_len  = LEN_AAI_NEXT;
        end else begin
          g_addr = {s_q.sh[39:17] & ADDR_MAX[23:1], 1'b0};
          g_len  = LEN_AAI_FIRST;
        end
      end
      CMD_SECTOR_ERASE:  g_kind = KIND_SECTOR;
      CMD_BLOCK32_ERASE: g_kind = KIND_BLOCK32;
      CMD_BLOCK64_ERASE: g_kind = KIND_BLOCK64;
      CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B: begin
        g_kind = KIND_CHIP;
        g_addr = 24'h000000;
        g_len  = LEN_SHORT;
      end
      default: ;
    endcase
  end

  // Protection verdict on the decoded target.
  fsp_guard u_guard (
    .level_i       (s_q.level),
    .top_lock_i    (s_q.top_sector_lock),
    .bottom_lock_i (s_q.bottom_sector_lock),
    .kind_i        (g_kind),
    .addr_i        (g_addr),
    .allow_o       (g_ok)
  );

  // =====================================================================
  // Next state.
  always_comb begin
    s_d           = s_q;
    s_d.op_start  = 1'b0;
    s_d.sck_prev  = sck_s;
    s_d.cs_n_prev = cs_n_s;

    // Internal operation timer; the busy bit drops when it runs out.
    if (s_q.busy) begin
      if (s_q.busy_cnt == BUSY_CNT_W'(1)) begin
        s_d.busy = 1'b0;
        if (!s_q.auto_increment_mode) begin
          s_d.write_enable_latch = 1'b0;
        end
      end else begin
        s_d.busy_cnt = s_q.busy_cnt - BUSY_CNT_W'(1);
      end
    end

    // Serial shifting while selected; the bit and byte counters restart on deselect.
    if (cs_n_s) begin
      s_d.phase    = PH_RX;
      s_d.bit_cnt  = 3'd0;
      s_d.byte_cnt = 3'd0;
      s_d.so_oe    = 1'b0;
    end else begin
      if (sck_rise && s_q.phase != PH_READ) begin
        s_d.rx      = rx_byte;
        s_d.bit_cnt = s_q.bit_cnt + 3'd1;
        if (s_q.bit_cnt == 3'd7) begin
          if (s_q.byte_cnt != 3'd7) begin
            s_d.byte_cnt = s_q.byte_cnt + 3'd1;
          end
          if (s_q.byte_cnt == 3'd0) begin
            s_d.opc = rx_byte;
            if (rx_byte == CMD_STATUS_READ || rx_byte == CMD_LOCK_READ) begin
              s_d.phase  = PH_READ;
              s_d.tx     = (rx_byte == CMD_STATUS_READ) ? s_q.st0 : s_q.st1;
              s_d.tx_cnt = 3'd0;
            end else if (s_q.busy) begin
              s_d.phase = PH_SKIP;
            end
          end else begin
            s_d.sh = {s_q.sh[31:0], rx_byte};
          end
        end
      end
      // Status bytes go out on falling edges, refreshed every byte for polling.
      if (sck_fall && s_q.phase == PH_READ) begin
        s_d.so     = s_q.tx[7];
        s_d.so_oe  = 1'b1;
        s_d.tx     = {s_q.tx[6:0], 1'b0};
        s_d.tx_cnt = s_q.tx_cnt + 3'd1;
        if (s_q.tx_cnt == 3'd7) begin
          s_d.tx = (s_q.opc == CMD_STATUS_READ) ? s_q.st0 : s_q.st1;
        end
      end
    end

    // Commands take effect on deselect after whole bytes only.
    if (cs_rise && s_q.phase == PH_RX && s_q.bit_cnt == 3'd0 &&
        s_q.byte_cnt != 3'd0 && !s_q.busy) begin
      case (s_q.opc)
        CMD_WRITE_ENABLE: begin
          if (s_q.byte_cnt == LEN_SHORT && !s_q.auto_increment_mode) begin
            s_d.write_enable_latch = 1'b1;
          end
        end
        CMD_WRITE_DISABLE: begin
          if (s_q.byte_cnt == LEN_SHORT) begin
            s_d.write_enable_latch  = 1'b0;
            s_d.ewsr = 1'b0;
            s_d.auto_increment_mode  = 1'b0;
          end
        end
        CMD_STATUS_WRITE_EN: begin
          if (s_q.byte_cnt == LEN_SHORT && !s_q.auto_increment_mode) begin
            s_d.ewsr = 1'b1;
          end
        end
        CMD_STATUS_WRITE: begin
          if ((s_q.byte_cnt == LEN_SR_ONE || s_q.byte_cnt == LEN_SR_TWO) &&
              !s_q.auto_increment_mode && (s_q.write_enable_latch || s_q.ewsr)) begin
            s_d.write_enable_latch  = 1'b0;
            s_d.ewsr = 1'b0;
            // Only level, lock and sector bits are taken; the rest is dropped.
            if (wr_ok) begin
              s_d.level = {sr0[ST_LVL_HI_BIT], sr0[ST_LVL_LO_BIT]};
              s_d.lock  = sr0[ST_LOCK_BIT];
              if (s_q.byte_cnt == LEN_SR_TWO) begin
                s_d.top_sector_lock = sr1[ST1_TOP_BIT];
                s_d.bottom_sector_lock = sr1[ST1_BOTTOM_BIT];
              end
            end
          end
        end
        default: begin
          // Array commands need the latch, the right length and a free range.
          if (g_kind != KIND_NONE && s_q.write_enable_latch && s_q.byte_cnt == g_len &&
              (!s_q.auto_increment_mode || g_kind == KIND_AAI)) begin
            if (g_ok) begin
              s_d.busy     = 1'b1;
              s_d.op_start = 1'b1;
              s_d.op.kind  = g_kind;
              s_d.op.addr  = g_addr;
              s_d.op.data  = g_data;
              case (g_kind)
                KIND_BYTE, KIND_AAI: s_d.busy_cnt = BUSY_CNT_W'(PROG_CYCLES);
                KIND_CHIP:           s_d.busy_cnt = BUSY_CNT_W'(CHIP_CYCLES);
                default:             s_d.busy_cnt = BUSY_CNT_W'(ERASE_CYCLES);
              endcase
              if (g_kind == KIND_AAI) begin
                s_d.auto_increment_mode      = 1'b1;
                s_d.aai_addr = g_addr + AAI_STEP;
              end
            end else if (s_q.auto_increment_mode) begin
              // The sequence has run into protected or absent memory.
              s_d.auto_increment_mode = 1'b0;
              s_d.write_enable_latch = 1'b0;
            end
          end
        end
      endcase
    end

    // Power-up values.
    if (RST_I) begin
      s_d           = '0;
      s_d.cs_n_prev = 1'b1;
      s_d.phase     = PH_RX;
      s_d.op.kind   = KIND_NONE;
      s_d.level     = RST_LEVEL;
      s_d.lock      = RST_LOCK;
      s_d.top_sector_lock       = RST_SECTOR;
      s_d.bottom_sector_lock       = RST_SECTOR;
    end

    // Register views; unused positions stay zero.
    s_d.st0                  = 8'h00;
    s_d.st0[ST_BUSY_BIT]     = s_d.busy;
    s_d.st0[ST_WEL_BIT]      = s_d.write_enable_latch;
    s_d.st0[ST_LVL_LO_BIT]   = s_d.level[0];
    s_d.st0[ST_LVL_HI_BIT]   = s_d.level[1];
    s_d.st0[ST_AUTO_INC_BIT] = s_d.auto_increment_mode;
    s_d.st0[ST_LOCK_BIT]     = s_d.lock;
    s_d.st1                  = 8'h00;
    s_d.st1[ST1_TOP_BIT]     = s_d.top_sector_lock;
    s_d.st1[ST1_BOTTOM_BIT]  = s_d.bottom_sector_lock;
  end

  // =====================================================================
  // State register.
  always_ff @(posedge CLOCK_I) begin
    s_q <= s_d;
  end

  // =====================================================================
  // Outputs, each taken from the state register.
  assign SO_O          = s_q.so;
  assign SO_OE_O       = s_q.so_oe;
  assign STATUS_O      = s_q.st0;
  assign LOCK_STATUS_O = s_q.st1;
  assign OP_START_O    = s_q.op_start;
  assign OP_O          = s_q.op;

endmodule // fsp_top

// ---- testbench/fsp_chk_sva.sv ----
// Assertions on the status and protection outputs of the flash block.
`timescale 1ns/1ps
module fsp_chk import fsp_pkg::*; #(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  // Clock, reset and guard pin.
  input wire logic       CLOCK_I,
  input wire logic       RST_I,
  input wire logic       WP_N_I,
  // Outputs under watch.
  input wire logic [7:0] STATUS_O,
  input wire logic [7:0] LOCK_STATUS_O,
  input wire logic       OP_START_O,
  input wire fsp_op_t    OP_O
);
  logic [21:0] busy_len_q, busy_len_d;

  // Counts how long the busy flag has stood.
  always_comb busy_len_d = STATUS_O[0] ? busy_len_q + 22'h1 : 22'h0;
  always_ff @(posedge CLOCK_I) begin
    busy_len_q <= RST_I ? 22'h0 : busy_len_d;
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  // ====
  // Assertions.
  a_reserved_zero:
    assert property (STATUS_O[5:4] == 2'b00 && LOCK_STATUS_O[7:4] == 4'h0
      && LOCK_STATUS_O[1:0] == 2'b00) else $error("Reserved bits not zero.");
  a_start_busy:
    assert property (OP_START_O |-> STATUS_O[0] && !$past(STATUS_O[0]))
      else $error("Start without busy rise.");
  a_start_enabled:
    assert property (OP_START_O |-> STATUS_O[1]) else $error("Start without latch.");
  a_chip_clear:
    assert property (OP_START_O && OP_O.kind == KIND_CHIP |-> STATUS_O[3:2] == 2'b00
      && LOCK_STATUS_O[3:2] == 2'b00) else $error("Chip erase under protection.");
  a_byte_range:
    assert property (OP_START_O && OP_O.kind == KIND_BYTE |-> STATUS_O[3:2] != 2'b11
      && !(STATUS_O[3:2] == 2'b01 && OP_O.addr >= LVL1_LO)
      && !(STATUS_O[3:2] == 2'b10 && OP_O.addr >= LVL2_LO)) else $error("Protected program.");
  a_sector_lock:
    assert property (OP_START_O && OP_O.kind == KIND_BYTE |->
      !(LOCK_STATUS_O[2] && OP_O.addr >= TOP_SECTOR_LO)
      && !(LOCK_STATUS_O[3] && OP_O.addr <= BOTTOM_SECTOR_HI)) else $error("Locked sector hit.");
  a_prog_time:
    assert property ($fell(STATUS_O[0]) && OP_O.kind == KIND_BYTE |->
      busy_len_q inside {[PROG_CYCLES - 1 : PROG_CYCLES + 1]}) else $error("Program time off.");
  a_latch_drop:
    assert property ($fell(STATUS_O[0]) && !STATUS_O[6] |-> !STATUS_O[1])
      else $error("Latch kept after op.");
  a_guard_hold:
    assert property ($changed(STATUS_O[7:2]) || $changed(LOCK_STATUS_O[3:2]) |->
      !$past(STATUS_O[7]) || $past(WP_N_I, 5)) else $error("Locked field changed.");

  // Main scenarios reached.
  cover property (OP_START_O && OP_O.kind == KIND_CHIP);
  cover property ($fell(STATUS_O[0]));
  cover property (STATUS_O[7] && !WP_N_I);
endmodule // fsp_chk

bind fsp_top fsp_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .WP_N_I(WP_N_I), .STATUS_O(STATUS_O),
  .LOCK_STATUS_O(LOCK_STATUS_O), .OP_START_O(OP_START_O), .OP_O(OP_O));

// ---- testbench/fsp_host.sv ----
// Host controller model that frames commands on the serial pins.
`timescale 1ns/1ps
module fsp_host (
  // Pins toward the device.
  output logic      ce_n_o,
  output logic      sck_o,
  output logic      si_o,
  // Reply from the device.
  input  wire logic so_i
);
  // Deselected, clock parked low in mode 0.
  initial begin
    ce_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // Sends bytes MSB first; returns the last eight bits seen on the reply line.
  task automatic frame(input logic [7:0] q[$], output logic [7:0] rd);
    rd = 8'h00;
    ce_n_o = 1'b0;
    #80;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        si_o = q[i][b];
        #80 sck_o = 1'b1;
        #70 rd = {rd[6:0], so_i};
        #10 sck_o = 1'b0;
      end
    end
    #80 ce_n_o = 1'b1;
    si_o = ~si_o; // Released line shows no stale value.
    #320;
  endtask
endmodule // fsp_host

// ---- testbench/tb.sv ----
// Self-checking bench of the flash status and write-protection block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb import fsp_pkg::*;;
  logic        clk, rst, ce_n, sck, si, so, wp_n, op_start, m_lock, m_tsp, m_bsp, m_wel, m_busy;
  logic        so_oe, m_aai;
  logic [7:0]  status, lock_st, rd;
  logic [1:0]  m_lvl;
  logic [31:0] r;
  fsp_op_t     op;
  int          bad_count, n_compared, n_start, e_start, cyc, n_oe;

  fsp_host i_host (.ce_n_o(ce_n), .sck_o(sck), .si_o(si), .so_i(so));
  fsp_top #(.PROG_CYCLES(200), .ERASE_CYCLES(300), .CHIP_CYCLES(400)) i_dut (
    .CLOCK_I(clk), .RST_I(rst), .CE_N_I(ce_n), .SCK_I(sck), .SI_I(si), .SO_O(so),
    .SO_OE_O(so_oe), .WP_N_I(wp_n), .STATUS_O(status), .LOCK_STATUS_O(lock_st),
    .OP_START_O(op_start), .OP_O(op));

  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts started operations and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (op_start === 1'b1) n_start++;
    if (so_oe === 1'b1) n_oe++;
    if (cyc > 40000) begin
      bad_count++;
      conclude();
    end
  end

  // ====
  // Model and tasks.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic prot(input logic [23:0] a);
    return m_lvl == 2'b11 || (m_lvl == 2'b01 && a >= 24'h030000) ||
      (m_lvl == 2'b10 && a >= 24'h020000) || (m_tsp && a >= 24'h03f000) ||
      (m_bsp && a < 24'h001000);
  endfunction

  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic send(input logic [7:0] q[$]);
    @(posedge clk) #2;
    i_host.frame(q, rd);
  endtask

  task automatic regs();
    `CHK("status", {m_lock, m_aai, 2'b00, m_lvl, m_wel, m_busy}, status)
    `CHK("lock_status", {4'h0, m_bsp, m_tsp, 2'b00}, lock_st)
    `CHK("starts", e_start, n_start)
  endtask

  task automatic write_enable_cmd();
    send('{8'h06});
    m_wel = 1'b1;
    regs();
  endtask

  task automatic poll();
    rd = 8'h01;
    for (int k = 0; k < 40 && rd[0] !== 1'b0; k++) send('{8'h05, 8'h00});
    m_busy = 1'b0;
    if (!m_aai) m_wel = 1'b0;
    `CHK("so_status", {m_lock, m_aai, 2'b00, m_lvl, m_wel, 1'b0}, rd)
  endtask

  task automatic status_write_cmd(input logic [7:0] s0, input logic [7:0] s1);
    send('{8'h01, s0, s1});
    if (m_wel && (wp_n || !m_lock)) begin
      m_lvl = s0[3:2];
      m_lock = s0[7];
      m_tsp = s1[2];
      m_bsp = s1[3];
    end
    m_wel = 1'b0;
    regs();
  endtask

  task automatic arr(input logic c, input logic [23:0] a, input logic [7:0] d);
    logic ok;
    ok = m_wel && (c ? (m_lvl == 2'b00 && !m_tsp && !m_bsp) : !prot(a));
    if (c) send('{d[0] ? 8'h60 : 8'hc7});
    else send('{8'h02, a[23:16], a[15:8], a[7:0], d});
    if (ok) e_start++;
    m_busy = ok;
    regs();
    if (ok) begin
      if (c) `CHK("kind", KIND_CHIP, op.kind)
      else `CHK("op", {KIND_BYTE, a, d}, {op.kind, op.addr, op.data[7:0]})
      poll();
      regs();
    end
  endtask

  // ====
  // Main sequence.
  initial begin
    {rst, wp_n} = 2'b11;
    {bad_count, n_compared, n_start, e_start, cyc, n_oe} = '0;
    {m_lock, m_tsp, m_bsp, m_wel, m_busy, m_aai} = '0;
    m_lvl = 2'b11;
    r = 32'h9c54;
    repeat (5) @(posedge clk);
    #2 rst = 1'b0;
    regs();
    write_enable_cmd();
    arr(1'b0, 24'h001234, 8'h3c);
    arr(1'b1, 24'h000000, 8'h00);
    send('{8'h04});
    m_wel = 1'b0;
    regs();
    status_write_cmd(8'h00, 8'h00);
    for (int i = 0; i < 14; i++) begin
      r = lfsr(r);
      write_enable_cmd();
      status_write_cmd({4'h7, r[1:0], 2'b11}, {4'hf, r[3:2], 2'b11});
      write_enable_cmd();
      arr(r[4], r[18] ? {6'h00, r[5] ? 6'h3f : 6'h00, r[17:6]} : {6'h00, r[17:0]},
          r[26:19]);
    end
    write_enable_cmd();
    status_write_cmd(8'h00, 8'h00);
    write_enable_cmd();
    arr(1'b1, 24'h000000, r[7:0]);
    write_enable_cmd();
    arr(1'b0, 24'h03fffe, r[15:8]);
    write_enable_cmd();
    status_write_cmd(8'h84, 8'h04);
    @(posedge clk) #2 wp_n = 1'b0;
    write_enable_cmd();
    status_write_cmd(8'h00, 8'h00);
    @(posedge clk) #2 wp_n = 1'b1;
    write_enable_cmd();
    status_write_cmd(8'h00, 8'h08);
    send('{8'h35, 8'h00});
    `CHK("so_lock", {4'h0, m_bsp, m_tsp, 2'b00}, rd)
    `CHK("so_oe_idle", 1'b0, so_oe)
    `CHK("so_oe_seen", 1'b1, n_oe > 0)
    // One auto-increment word, then write-disable ends the mode.
    write_enable_cmd();
    send('{8'had, 8'h01, 8'h00, 8'h01, r[7:0], r[15:8]});
    e_start++;
    m_busy = 1'b1;
    m_aai = 1'b1;
    regs();
    `CHK("aai_op", {KIND_AAI, 24'h010000, r[7:0], r[15:8]}, op)
    poll();
    send('{8'h04});
    m_aai = 1'b0;
    m_wel = 1'b0;
    regs();
    conclude();
  end
endmodule // tb
